// *** pin_ctrl_pkg.sv ***
package pin_ctrl_pkg;
    localparam int        DATA_WIDTH    = 8;
    localparam int        ADDR_WIDTH    = 4;
    // register index (byte address on the plain port)
    localparam logic [3:0] PULL_EN_ADDR  = 4'h0;
    localparam logic [3:0] SLEW_EN_ADDR  = 4'h1;
    localparam logic [3:0] PULL_DIR_ADDR = 4'h2;
    localparam logic [3:0] DRIVE_ADDR    = 4'h3;
    localparam logic [3:0] DIR_ADDR      = 4'h4;
    // implemented bits of each register
    localparam logic [7:0] PULL_MASK     = 8'hfd;
    localparam logic [7:0] OUTCTL_MASK   = 8'hfe;
    localparam logic [7:0] DIR_MASK      = 8'hfd;
    // reset values
    localparam logic [7:0] PULL_EN_RST   = 8'h00;
    localparam logic [7:0] SLEW_EN_RST   = 8'h00;
    localparam logic [7:0] PULL_DIR_RST  = 8'h00;
    localparam logic [7:0] DRIVE_RST     = 8'h00;
    localparam logic [7:0] DIR_RST       = 8'h00;
endpackage

// *** pin_ctrl_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface pin_ctrl_if;
    logic [7:0] pull_en;
    logic [7:0] pull_dir;
    logic [7:0] slew_en;
    logic [7:0] drive;
    logic [7:0] dir;
    modport regs (output pull_en, pull_dir, slew_en, drive, dir);
    modport pads (input pull_en, pull_dir, slew_en, drive, dir);
endinterface
`default_nettype wire

// *** pad_decode.sv ***
`timescale 1ns/1ps
`default_nettype none
module pad_decode (
    pin_ctrl_if.pads   cfg,
    output logic [7:0] pullup_on,
    output logic [7:0] pulldown_on,
    output logic [7:0] slew_on,
    output logic [7:0] drive_hi,
    output logic [7:0] driver_on
);
    // output when direction bit is 1
    assign driver_on   = cfg.dir;
    // resistor only on inputs with pull enabled; polarity chosen by pull_dir bit
    assign pullup_on   = cfg.pull_en & ~cfg.dir & ~cfg.pull_dir;
    assign pulldown_on = cfg.pull_en & ~cfg.dir & cfg.pull_dir;
    // slew and drive only matter for outputs
    assign slew_on     = cfg.slew_en & cfg.dir;
    assign drive_hi    = cfg.drive & cfg.dir;
endmodule
`default_nettype wire

// *** port_b_pin_control.sv ***
// Chosen here: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - one pull enable bit per pin, except pin 1
// - outputs force pulling resistor off
// - pull enable 0 off, 1 on
// - slew limit bits for pins 7..1
// - inputs ignore slew and drive bits
// - pull direction 0 up, 1 down
// - pull direction bit acts only when pull enabled
// - drive strength bits for pins 7..1
// - direction 1 output, 0 input
// - reset leaves inputs, pulls off
module port_b_pin_control (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic [3:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    output logic      [7:0] pullup_en,
    output logic      [7:0] pulldown_en,
    output logic      [7:0] slew_limit,
    output logic      [7:0] drive_high,
    output logic      [7:0] output_en
);
    logic [7:0] pull_en_q;
    logic [7:0] pull_dir_q;
    logic [7:0] slew_q;
    logic [7:0] drive_q;
    logic [7:0] dir_q;
    logic [7:0] rdata_d;
    logic [7:0] pu_w;
    logic [7:0] pd_w;
    logic [7:0] sl_w;
    logic [7:0] dh_w;
    logic [7:0] oe_w;

    // true when the port address selects register index idx
    function automatic logic hit(input logic [3:0] a,
                                 input logic [3:0] idx);
        return a == idx;
    endfunction

    // write decode, one strobe per control register
    wire        wr_pe  = wr && hit(addr, pin_ctrl_pkg::PULL_EN_ADDR);
    wire        wr_se  = wr && hit(addr, pin_ctrl_pkg::SLEW_EN_ADDR);
    wire        wr_pd  = wr && hit(addr, pin_ctrl_pkg::PULL_DIR_ADDR);
    wire        wr_ds  = wr && hit(addr, pin_ctrl_pkg::DRIVE_ADDR);
    wire        wr_dd  = wr && hit(addr, pin_ctrl_pkg::DIR_ADDR);

    pin_ctrl_if cfg_bus ();
    assign cfg_bus.pull_en  = pull_en_q;
    assign cfg_bus.pull_dir = pull_dir_q;
    assign cfg_bus.slew_en  = slew_q;
    assign cfg_bus.drive    = drive_q;
    assign cfg_bus.dir      = dir_q;

    pad_decode u_dec (
        .cfg         (cfg_bus.pads),
        .pullup_on   (pu_w),
        .pulldown_on (pd_w),
        .slew_on     (sl_w),
        .drive_hi    (dh_w),
        .driver_on   (oe_w)
    );

    // read mux, unmapped reads zero
    always_comb begin
        if (addr == pin_ctrl_pkg::PULL_EN_ADDR) begin
            rdata_d = pull_en_q;
        end else if (addr == pin_ctrl_pkg::SLEW_EN_ADDR) begin
            rdata_d = slew_q;
        end else if (addr == pin_ctrl_pkg::PULL_DIR_ADDR) begin
            rdata_d = pull_dir_q;
        end else if (addr == pin_ctrl_pkg::DRIVE_ADDR) begin
            rdata_d = drive_q;
        end else if (addr == pin_ctrl_pkg::DIR_ADDR) begin
            rdata_d = dir_q;
        end else begin
            rdata_d = 8'h00;
        end
    end

    // control registers, masked so dead bits stay zero
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pull_en_q  <= pin_ctrl_pkg::PULL_EN_RST;
            slew_q     <= pin_ctrl_pkg::SLEW_EN_RST;
            pull_dir_q <= pin_ctrl_pkg::PULL_DIR_RST;
            drive_q    <= pin_ctrl_pkg::DRIVE_RST;
            dir_q      <= pin_ctrl_pkg::DIR_RST;
        end else begin
            if (wr_pe) pull_en_q <= wdata & pin_ctrl_pkg::PULL_MASK;
            if (wr_se) slew_q <= wdata & pin_ctrl_pkg::OUTCTL_MASK;
            if (wr_pd) pull_dir_q <= wdata & pin_ctrl_pkg::PULL_MASK;
            if (wr_ds) drive_q <= wdata & pin_ctrl_pkg::OUTCTL_MASK;
            if (wr_dd) dir_q <= wdata & pin_ctrl_pkg::DIR_MASK;
        end
    end

    // registered outputs: read data and pad controls
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata       <= 8'h00;
            pullup_en   <= 8'h00;
            pulldown_en <= 8'h00;
            slew_limit  <= 8'h00;
            drive_high  <= 8'h00;
            output_en   <= 8'h00;
        end else begin
            rdata       <= rd ? rdata_d : 8'h00;
            pullup_en   <= pu_w;
            pulldown_en <= pd_w;
            slew_limit  <= sl_w;
            drive_high  <= dh_w;
            output_en   <= oe_w;
        end
    end

    // pulls never act on a driven pin
    AST_OUT_NO_PULL: assert property (@(posedge clk)
        disable iff (!rstn)
        ((pullup_en | pulldown_en) & output_en) == 8'h00)
        else $error("pull active on an output pin");

    // a pull enable write reaches the pads two edges later
    AST_PULL_EN: assert property (@(posedge clk)
        disable iff (!rstn)
        wr_pe ##1 !wr_dd |=> (pullup_en | pulldown_en) ==
            ($past(wdata, 2) & pin_ctrl_pkg::PULL_MASK & ~output_en))
        else $error("pull enable not applied");

    // one polarity at a time
    AST_PULL_POL: assert property (@(posedge clk)
        disable iff (!rstn)
        (pullup_en & pulldown_en) == 8'h00)
        else $error("pullup and pulldown together");

    // no resistor without its enable bit
    AST_PULL_GATE: assert property (@(posedge clk)
        disable iff (!rstn)
        ((pullup_en | pulldown_en) & ~$past(pull_en_q)) == 8'h00)
        else $error("pull active without enable");

    // slew and drive are dead on inputs
    AST_IN_IGNORE: assert property (@(posedge clk)
        disable iff (!rstn)
        ((slew_limit | drive_high) & ~output_en) == 8'h00)
        else $error("slew or drive on an input");

    // a direction write reaches the driver enables two edges later
    AST_DIR: assert property (@(posedge clk)
        disable iff (!rstn)
        wr_dd |=> ##1 output_en == ($past(wdata, 2) & pin_ctrl_pkg::DIR_MASK))
        else $error("direction not applied");

    // bits with no control never get set
    AST_DEAD_BITS: assert property (@(posedge clk)
        disable iff (!rstn)
        pull_en_q[1] == 1'b0 && slew_q[0] == 1'b0 && drive_q[0] == 1'b0 &&
            pull_dir_q[1] == 1'b0 && dir_q[1] == 1'b0)
        else $error("unimplemented bit set");

    // a slew write reaches the pads two edges later
    AST_SLEW_BITS: assert property (@(posedge clk)
        disable iff (!rstn)
        wr_se ##1 !wr_dd |=> slew_limit ==
            ($past(wdata, 2) & pin_ctrl_pkg::OUTCTL_MASK & output_en))
        else $error("slew bits not applied");

    // drive strength register reads back
    AST_READ: assert property (@(posedge clk)
        disable iff (!rstn)
        rd && addr == pin_ctrl_pkg::DRIVE_ADDR |=> rdata == $past(drive_q))
        else $error("drive read wrong");

    // pullup only where the polarity bit is 0
    AST_PULLUP_SEL: assert property (@(posedge clk)
        disable iff (!rstn)
        pullup_en == ($past(pull_en_q) & ~$past(pull_dir_q) & ~output_en))
        else $error("pullup selection wrong");

    // pulldown only where the polarity bit is 1
    AST_PULLDOWN_SEL: assert property (@(posedge clk)
        disable iff (!rstn)
        pulldown_en == ($past(pull_en_q) & $past(pull_dir_q) & ~output_en))
        else $error("pulldown selection wrong");

    // enable bit 1 turns the resistor on for an input pin
    AST_PULL_ON: assert property (@(posedge clk)
        disable iff (!rstn)
        (pullup_en | pulldown_en) == ($past(pull_en_q) & ~output_en))
        else $error("pull enable encoding wrong");

    // high drive only on outputs with the bit set
    AST_DRIVE_BITS: assert property (@(posedge clk)
        disable iff (!rstn)
        drive_high == ($past(drive_q) & output_en))
        else $error("drive strength wrong");

    // slew limit follows its register on outputs
    AST_SLEW_FOLLOW: assert property (@(posedge clk)
        disable iff (!rstn)
        slew_limit == ($past(slew_q) & output_en))
        else $error("slew limit wrong");

    // driver enable is the registered direction
    AST_OE_FOLLOW: assert property (@(posedge clk)
        disable iff (!rstn)
        output_en == $past(dir_q))
        else $error("driver enable wrong");

    // pad outputs of dead bit positions stay low
    AST_OUT_DEAD: assert property (@(posedge clk)
        disable iff (!rstn)
        slew_limit[0] == 1'b0 && drive_high[0] == 1'b0 &&
            pullup_en[1] == 1'b0 && pulldown_en[1] == 1'b0 &&
            output_en[1] == 1'b0)
        else $error("dead pad bit active");

    // pull enable register reads back
    AST_RD_PULL_EN: assert property (@(posedge clk)
        disable iff (!rstn)
        rd && addr == pin_ctrl_pkg::PULL_EN_ADDR |=> rdata == $past(pull_en_q))
        else $error("pull enable read wrong");

    // slew register reads back
    AST_RD_SLEW: assert property (@(posedge clk)
        disable iff (!rstn)
        rd && addr == pin_ctrl_pkg::SLEW_EN_ADDR |=> rdata == $past(slew_q))
        else $error("slew read wrong");

    // pull direction register reads back
    AST_RD_PULL_DIR: assert property (@(posedge clk)
        disable iff (!rstn)
        rd && addr == pin_ctrl_pkg::PULL_DIR_ADDR |=>
            rdata == $past(pull_dir_q))
        else $error("pull direction read wrong");

    // direction register reads back
    AST_RD_DIR: assert property (@(posedge clk)
        disable iff (!rstn)
        rd && addr == pin_ctrl_pkg::DIR_ADDR |=> rdata == $past(dir_q))
        else $error("direction read wrong");

    // unmapped addresses read zero
    AST_RD_UNMAPPED: assert property (@(posedge clk)
        disable iff (!rstn)
        rd && addr > pin_ctrl_pkg::DIR_ADDR |=> rdata == 8'h00)
        else $error("unmapped read not zero");

    // unmapped writes change nothing
    AST_WR_UNMAPPED: assert property (@(posedge clk)
        disable iff (!rstn)
        wr && addr > pin_ctrl_pkg::DIR_ADDR |=> $stable(pull_en_q) &&
            $stable(slew_q) && $stable(pull_dir_q) && $stable(drive_q) &&
            $stable(dir_q))
        else $error("unmapped write took effect");

    // reset leaves pins undriven with pulls off
    AST_RESET_OUT: assert property (@(posedge clk)
        !rstn |-> (pullup_en | pulldown_en | output_en) == 8'h00)
        else $error("pin active during reset");

    // pull enable write lands masked
    AST_WR_PULL_EN: assert property (@(posedge clk)
        disable iff (!rstn)
        wr_pe |=> pull_en_q == ($past(wdata) & pin_ctrl_pkg::PULL_MASK))
        else $error("pull enable write wrong");

    // slew write lands masked
    AST_WR_SLEW: assert property (@(posedge clk)
        disable iff (!rstn)
        wr_se |=> slew_q == ($past(wdata) & pin_ctrl_pkg::OUTCTL_MASK))
        else $error("slew write wrong");

    // pull direction write lands masked
    AST_WR_PULL_DIR: assert property (@(posedge clk)
        disable iff (!rstn)
        wr_pd |=> pull_dir_q == ($past(wdata) & pin_ctrl_pkg::PULL_MASK))
        else $error("pull direction write wrong");

    // drive write lands masked
    AST_WR_DRIVE: assert property (@(posedge clk)
        disable iff (!rstn)
        wr_ds |=> drive_q == ($past(wdata) & pin_ctrl_pkg::OUTCTL_MASK))
        else $error("drive write wrong");

    // pull enable holds without a write to it
    AST_HOLD_PULL_EN: assert property (@(posedge clk)
        disable iff (!rstn)
        !wr_pe |=> $stable(pull_en_q))
        else $error("pull enable changed unasked");

    // slew holds without a write to it
    AST_HOLD_SLEW: assert property (@(posedge clk)
        disable iff (!rstn)
        !wr_se |=> $stable(slew_q))
        else $error("slew changed unasked");

    // pull direction holds without a write to it
    AST_HOLD_PULL_DIR: assert property (@(posedge clk)
        disable iff (!rstn)
        !wr_pd |=> $stable(pull_dir_q))
        else $error("pull direction changed unasked");

    // drive holds without a write to it
    AST_HOLD_DRIVE: assert property (@(posedge clk)
        disable iff (!rstn)
        !wr_ds |=> $stable(drive_q))
        else $error("drive changed unasked");

    // direction holds without a write to it
    AST_HOLD_DIR: assert property (@(posedge clk)
        disable iff (!rstn)
        !wr_dd |=> $stable(dir_q))
        else $error("direction changed unasked");
endmodule
`default_nettype wire

// *** pad_board.sv ***
`timescale 1ns/1ps
`default_nettype none
module pad_board (
    input  wire logic [7:0] pullup_en,
    input  wire logic [7:0] pulldown_en,
    input  wire logic [7:0] output_en,
    output logic      [7:0] floating
);
    // a pin floats when nothing drives it and no resistor holds it
    assign floating = ~(pullup_en | pulldown_en | output_en);
endmodule
`default_nettype wire

// *** tb_port_b_pin_control.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_port_b_pin_control;
    logic        clk;
    logic        rstn;
    logic        wr;
    logic        rd;
    logic [3:0]  addr;
    logic [7:0]  wdata, rdata, pu, pdn, sl, dh, oe, flt;
    logic [15:0] r = 16'h0010;
    int          m [0:4];
    int          n_mismatch = 0;
    int          comparisons = 0;

    port_b_pin_control uut (.clk(clk), .rstn(rstn), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pullup_en(pu),
        .pulldown_en(pdn), .slew_limit(sl), .drive_high(dh),
        .output_en(oe));
    pad_board board (.pullup_en(pu), .pulldown_en(pdn), .output_en(oe),
        .floating(flt));

    // clock source, 20 ns period
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one-cycle write, model keeps only implemented bits
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] mk [0:4];
        mk = '{8'hfd, 8'hfe, 8'hfd, 8'hfe, 8'hfd};
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        if (a < 5) m[a] = int'(d & mk[a]);
    endtask

    // read data stand in the cycle after the strobe, zero afterwards
    task automatic rd_check(input logic [3:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(rdata, (a < 5) ? 8'(m[a]) : 8'h00);
        @(negedge clk);
        chk(rdata, 8'h00);
    endtask

    // pad outputs from the model: 0 pull en, 1 slew, 2 pull dir, 3 drive
    task automatic pads_check();
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk(pu, 8'(m[0] & ~m[2] & ~m[4]));
        chk(pdn, 8'(m[0] & m[2] & ~m[4]));
        chk(sl, 8'(m[1] & m[4]));
        chk(dh, 8'(m[3] & m[4]));
        chk(oe, 8'(m[4]));
        chk(flt, 8'(~(m[0] | m[4])));
    endtask

    task automatic end_of_test();
        if (n_mismatch == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // reset, reset values, then random traffic over addresses 0 to 7
    initial begin
        {wr, rd, addr, wdata, rstn} = '0;
        for (int i = 0; i < 5; i++) m[i] = 0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        pads_check();
        for (int i = 0; i < 8; i++) rd_check(4'(i));
        repeat (80) begin
            r = lfsr(r);
            wr_reg({1'b0, r[2:0]}, r[15:8]);
            pads_check();
            rd_check({1'b0, r[2:0]});
        end
        end_of_test();
    end

    // watchdog against a hung run
    initial begin
        #100000;
        n_mismatch++;
        end_of_test();
    end
endmodule
`default_nettype wire
